// ### rtl/rsd_top.sv
// rotary switch decoder: control and result registers and step counter
`timescale 1ns/1ps
`include "rsd_cfg.svh"
module rsd_top (
  input  wire logic               sys_clk,
  input  wire logic               rot_clk,
  input  wire logic               rst,
  input  wire logic               ext_rst_n,
  input  wire logic               low_supply_lockout,
  input  rsd_pkg::rsd_req_t       req,
  output logic [7:0]              reg_rdata,
  output logic                    irq,
  input  wire logic [2:0]         term_in,
  output rsd_pkg::rsd_pins_t      pins
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic                  rst_raw;
  logic [1:0]            rsync_q;
  logic                  sys_rst;
  rsd_pkg::rsd_steps_t   steps;
  rsd_pkg::rsd_sys_st_t  q;
  rsd_pkg::rsd_sys_st_t  d;
  logic                  wr_ctrl;
  logic                  rd_res;
  logic                  up_ev;
  logic                  dn_ev;
  logic                  step;
  logic                  sdir;
  logic [6:0]            base;

  // read value of an address, zero where nothing is mapped
  function automatic logic [7:0] read_mux(input logic [7:0]           a,
                                          input rsd_pkg::rsd_sys_st_t s);
    if (a == `RSD_ADDR_CTRL) begin
      read_mux = {s.run, `RSD_CTRL_PAD};
    end else if (a == `RSD_ADDR_RES) begin
      read_mux = {s.dir, s.cnt};
    end else begin
      read_mux = `RSD_DATA_NONE;
    end
  endfunction

  // address match for a strobe
  function automatic logic hit(input logic       strobe,
                               input logic [7:0] a,
                               input logic [7:0] want);
    hit = strobe && (a == want);
  endfunction

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  // power-on, the reset pin and supply lockout all reset every flop
  assign rst_raw = rst | ~ext_rst_n | low_supply_lockout;

  // asserted at once, released two edges later so no flop sees a runt
  always_ff @(posedge sys_clk or posedge rst_raw) begin
    if (rst_raw) begin
      rsync_q <= 2'h3;
    end else begin
      rsync_q <= {rsync_q[0], 1'b0};
    end
  end
  assign sys_rst = rsync_q[1];

  // ----------------------------------------------------------------
  // link-side scanner
  // ----------------------------------------------------------------
  rsd_scan u_scan (
    .rot_clk (rot_clk),
    .rst_raw (rst_raw),
    .run     (q.run),
    .term_in (term_in),
    .pins    (pins),
    .steps   (steps)
  );

  // ----------------------------------------------------------------
  // register access and step counting
  // ----------------------------------------------------------------
  always_comb begin
    d = q;

    // step toggles cross from the link clock
    d.up_m = steps.up_tog;
    d.up_s = q.up_m;
    d.up_p = q.up_s;
    d.dn_m = steps.dn_tog;
    d.dn_s = q.dn_m;
    d.dn_p = q.dn_s;
    up_ev  = q.up_s ^ q.up_p;
    dn_ev  = q.dn_s ^ q.dn_p;

    // steps still in flight after a stop are dropped
    step = q.run & (up_ev | dn_ev);
    // up wins if both land in one cycle
    sdir = ~up_ev;

    wr_ctrl = hit(req.wr, req.addr, `RSD_ADDR_CTRL);
    rd_res  = hit(req.rd, req.addr, `RSD_ADDR_RES);

    if (wr_ctrl) begin
      d.run = req.wdata[`RSD_RUN_BIT];
    end

    if (req.rd) begin
      d.rdata = read_mux(req.addr, q);
    end

    // a read empties the count before this cycle's step lands
    base = rd_res ? `RSD_CNT_ZERO : q.cnt;

    if (step) begin
      if (base == `RSD_CNT_ZERO || q.dir != sdir) begin
        d.cnt = `RSD_CNT_ONE;
        d.dir = sdir;
      end else if (base == `RSD_CNT_MAX) begin
        d.cnt = `RSD_CNT_MAX;
      end else begin
        d.cnt = 7'(base + `RSD_CNT_ONE);
      end
    end else begin
      d.cnt = base;
    end

    // interrupt stands while unread steps remain
    d.irq = (d.cnt != `RSD_CNT_ZERO);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign irq       = q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  ctl_run_a: assert property (wr_ctrl |=> q.run == $past(req.wdata[`RSD_RUN_BIT]))
    else $error("run bit not taken from control write");

  ctl_keep_a: assert property (!wr_ctrl |=> q.run == $past(q.run))
    else $error("run bit changed without a write");

  ctl_read_a: assert property (hit(req.rd, req.addr, `RSD_ADDR_CTRL) |=>
      reg_rdata == {$past(q.run), `RSD_CTRL_PAD})
    else $error("control read wrong");

  res_read_a: assert property (rd_res |=> reg_rdata == $past({q.dir, q.cnt}))
    else $error("result read wrong");

  res_clear_a: assert property ((rd_res && !step) |=> q.cnt == `RSD_CNT_ZERO)
    else $error("count not cleared by read");

  irq_track_a: assert property (irq == (q.cnt != `RSD_CNT_ZERO))
    else $error("interrupt does not follow count");

  irq_rise_a: assert property ((step && q.cnt == `RSD_CNT_ZERO) |=> irq ##0
      (q.cnt == `RSD_CNT_ONE))
    else $error("movement raised no interrupt");

  cnt_inc_a: assert property ((step && !rd_res && sdir == q.dir &&
      q.cnt != `RSD_CNT_ZERO && q.cnt != `RSD_CNT_MAX) |=>
      q.cnt == 7'($past(q.cnt) + `RSD_CNT_ONE))
    else $error("count did not advance by one");

  cnt_sat_a: assert property ((step && !rd_res && sdir == q.dir &&
      q.cnt == `RSD_CNT_MAX) |=> q.cnt == `RSD_CNT_MAX)
    else $error("count wrapped");

  dir_flip_a: assert property ((step && sdir != q.dir) |=>
      (q.cnt == `RSD_CNT_ONE) && (q.dir == $past(sdir)))
    else $error("direction change did not restart count");

  stop_hold_a: assert property ((!q.run && !rd_res) |=>
      q.cnt == $past(q.cnt))
    else $error("count moved while stopped");

  step_dir_a: assert property ((q.run && up_ev) |=> q.dir == 1'b0)
    else $error("up step recorded as down");

endmodule

// ### rtl/rsd_cfg.svh
// constants of the rotary switch decoder
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

// register map
`define RSD_ADDR_CTRL   8'h70
`define RSD_ADDR_RES    8'h72
`define RSD_RUN_BIT     7
`define RSD_DIR_BIT     7
`define RSD_CTRL_PAD    7'h00
`define RSD_DATA_NONE   8'h00

// step counter
`define RSD_CNT_ZERO    7'h00
`define RSD_CNT_ONE     7'h01
`define RSD_CNT_MAX     7'h7f

// scan timing in link clock cycles: last tick of each drive phase
`define RSD_SETTLE_LAST 4'h7
`define RSD_TMR_ZERO    4'h0
`define RSD_TMR_ONE     4'h1

// contact pair codes, advancing by one is an up step
`define RSD_PAIR_AB     2'h0
`define RSD_PAIR_BC     2'h1
`define RSD_PAIR_CA     2'h2

// terminal indexes
`define RSD_TERM_A      0
`define RSD_TERM_B      1
`define RSD_TERM_C      2

`endif

// ### rtl/rsd_pkg.sv
// types shared by the rotary switch decoder modules
package rsd_pkg;

  typedef enum logic [3:0] {
    RSD_IDLE  = 4'b0001,
    RSD_DRV_A = 4'b0010,
    RSD_DRV_B = 4'b0100,
    RSD_DRV_C = 4'b1000
  } rsd_scan_t;

  typedef struct packed {
    logic [2:0] oe;
    logic [2:0] out;
    logic [2:0] pu;
  } rsd_pins_t;

  typedef struct packed {
    logic up_tog;
    logic dn_tog;
  } rsd_steps_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } rsd_req_t;

  typedef struct packed {
    logic       run_m;
    logic       run_s;
    logic [2:0] term_m;
    logic [2:0] term_s;
    rsd_scan_t  scan;
    logic [3:0] tmr;
    logic       ab;
    logic       ca;
    logic       bc;
    logic       ref_vld;
    logic [1:0] ref_pair;
    rsd_steps_t steps;
    rsd_pins_t  pins;
  } rsd_link_st_t;

  typedef struct packed {
    logic       run;
    logic       up_m;
    logic       up_s;
    logic       up_p;
    logic       dn_m;
    logic       dn_s;
    logic       dn_p;
    logic       dir;
    logic [6:0] cnt;
    logic [7:0] rdata;
    logic       irq;
  } rsd_sys_st_t;

endpackage

// ### rtl/rsd_scan.sv
// link-clock scanner: drives the terminals and emits step toggles
`timescale 1ns/1ps
`include "rsd_cfg.svh"
module rsd_scan (
  input  wire logic               rot_clk,
  input  wire logic               rst_raw,
  input  wire logic               run,
  input  wire logic [2:0]         term_in,
  output rsd_pkg::rsd_pins_t      pins,
  output rsd_pkg::rsd_steps_t     steps
);

  logic [1:0]            rsync_q;
  logic                  link_rst;
  rsd_pkg::rsd_link_st_t q;
  rsd_pkg::rsd_link_st_t d;
  logic                  pair_ok;
  logic [1:0]            pair;

  function automatic logic [1:0] pair_next(input logic [1:0] p);
    pair_next = (p == `RSD_PAIR_CA) ? `RSD_PAIR_AB : 2'(p + 2'h1);
  endfunction

  // ----------------------------------------------------------------
  // reset: asserted at once, released on this clock
  // ----------------------------------------------------------------
  always_ff @(posedge rot_clk or posedge rst_raw) begin
    if (rst_raw) begin
      rsync_q <= 2'h3;
    end else begin
      rsync_q <= {rsync_q[0], 1'b0};
    end
  end
  assign link_rst = rsync_q[1];

  // ----------------------------------------------------------------
  // scan machine
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.run_m  = run;
    d.run_s  = q.run_m;
    d.term_m = term_in;
    d.term_s = q.term_m;
    pair_ok  = ({q.ab, q.bc, q.ca & ~q.term_s[`RSD_TERM_A]} == 3'b100) ||
               ({q.ab, q.bc, q.ca & ~q.term_s[`RSD_TERM_A]} == 3'b010) ||
               ({q.ab, q.bc, q.ca & ~q.term_s[`RSD_TERM_A]} == 3'b001);
    pair     = q.ab ? `RSD_PAIR_AB : (q.bc ? `RSD_PAIR_BC : `RSD_PAIR_CA);
    d.tmr    = 4'(q.tmr + `RSD_TMR_ONE);
    case (q.scan)
      rsd_pkg::RSD_IDLE: begin
        d.tmr     = `RSD_TMR_ZERO;
        d.ref_vld = 1'b0;
        if (q.run_s) begin
          d.scan = rsd_pkg::RSD_DRV_A;
        end
      end
      rsd_pkg::RSD_DRV_A: begin
        if (q.tmr == `RSD_SETTLE_LAST) begin
          d.tmr  = `RSD_TMR_ZERO;
          d.ab   = ~q.term_s[`RSD_TERM_B];
          d.ca   = ~q.term_s[`RSD_TERM_C];
          d.scan = rsd_pkg::RSD_DRV_B;
        end
      end
      rsd_pkg::RSD_DRV_B: begin
        if (q.tmr == `RSD_SETTLE_LAST) begin
          d.tmr  = `RSD_TMR_ZERO;
          d.bc   = ~q.term_s[`RSD_TERM_C];
          d.scan = rsd_pkg::RSD_DRV_C;
        end
      end
      rsd_pkg::RSD_DRV_C: begin
        if (q.tmr == `RSD_SETTLE_LAST) begin
          d.tmr  = `RSD_TMR_ZERO;
          d.scan = rsd_pkg::RSD_DRV_A;
          if (pair_ok) begin
            // first pair only sets the reference
            if (q.ref_vld && pair != q.ref_pair) begin
              if (pair == pair_next(q.ref_pair)) begin
                d.steps.up_tog = ~q.steps.up_tog;
              end else begin
                d.steps.dn_tog = ~q.steps.dn_tog;
              end
            end
            d.ref_vld  = 1'b1;
            d.ref_pair = pair;
          end
        end
      end
      default: begin
        d.scan = rsd_pkg::RSD_IDLE;
      end
    endcase
    if (!q.run_s) begin
      d.scan    = rsd_pkg::RSD_IDLE;
      d.ref_vld = 1'b0;
    end
    // while scanning, one terminal driven low, the other two pulled up; idle drives and pulls none
    d.pins.out = 3'h0;
    d.pins.oe  = {d.scan == rsd_pkg::RSD_DRV_C, d.scan == rsd_pkg::RSD_DRV_B,
                  d.scan == rsd_pkg::RSD_DRV_A};
    d.pins.pu  = (d.scan == rsd_pkg::RSD_IDLE) ? 3'h0 : ~d.pins.oe;
  end

  always_ff @(posedge rot_clk or posedge link_rst) begin
    if (link_rst) begin
      q      <= '0;
      q.scan <= rsd_pkg::RSD_IDLE;
    end else begin
      q <= d;
    end
  end

  assign pins  = q.pins;
  assign steps = q.steps;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge rot_clk); endclocking
  default disable iff (link_rst);

  one_drive_a: assert property ($onehot0(q.pins.oe))
    else $error("more than one terminal driven");
  pull_other_a: assert property ((q.scan != rsd_pkg::RSD_IDLE) |->
      ($onehot(q.pins.oe) && q.pins.pu == ~q.pins.oe))
    else $error("pull-ups not on the sensed terminals");
  stop_quiet_a: assert property (!q.run_s |=> (q.scan == rsd_pkg::RSD_IDLE) &&
      (q.pins.oe == 3'h0))
    else $error("scan runs with run cleared");
  first_pair_a: assert property (!q.ref_vld |=> $stable(q.steps))
    else $error("step reported before reference");
  run_start_a: assert property ((q.run_s && q.scan == rsd_pkg::RSD_IDLE)
      |=> q.scan == rsd_pkg::RSD_DRV_A)
    else $error("scan did not start");

endmodule

// ### test/rsd_switch.sv
// rotary switch model: shorts one contact pair and resolves the terminal wires
`timescale 1ns/1ps
module rsd_switch (
  input  wire logic          rot_clk,
  input  rsd_pkg::rsd_pins_t pins,
  input  wire logic          closed,
  input  wire logic [1:0]    pair,
  output logic [2:0]         term_in
);
  logic       flt;
  logic [2:0] lvl;

  // a terminal neither driven nor pulled up wanders every cycle
  initial flt = 1'b0;
  always @(posedge rot_clk) flt <= ~flt;

  always_comb begin
    int   a;
    int   b;
    logic j;
    a = 0;
    b = 0;
    j = 1'b0;
    for (int i = 0; i < 3; i++) begin
      lvl[i] = pins.oe[i] ? pins.out[i] : (pins.pu[i] ? 1'b1 : flt);
    end
    // pair code 0 joins a-b, 1 joins b-c, 2 joins c-a
    a = int'(pair);
    b = (a + 1) % 3;
    term_in = lvl;
    if (closed && pair != 2'h3) begin
      if (pins.oe[a]) begin
        j = pins.out[a];
      end else if (pins.oe[b]) begin
        j = pins.out[b];
      end else if (pins.pu[a] | pins.pu[b]) begin
        j = 1'b1;
      end else begin
        j = flt;
      end
      term_in[a] = j;
      term_in[b] = j;
    end
  end
endmodule

// ### test/rotary_switch_decoder_tb_top.sv
// self-checking bench for the rotary switch decoder
`timescale 1ns/1ps
module rotary_switch_decoder_tb_top;
  logic               sys_clk;
  logic               rot_clk;
  logic               rst;
  logic               ext_rst_n;
  logic               low_supply_lockout;
  rsd_pkg::rsd_req_t  req;
  logic [7:0]         reg_rdata;
  logic               irq;
  logic [2:0]         term_in;
  rsd_pkg::rsd_pins_t pins;
  logic               sw_closed;
  logic [1:0]         sw_pair;
  int                 num_errors;
  int                 check_count;
  int                 pos;

  rsd_top DUT (
    .sys_clk(sys_clk), .rot_clk(rot_clk), .rst(rst), .ext_rst_n(ext_rst_n),
    .low_supply_lockout(low_supply_lockout), .req(req), .reg_rdata(reg_rdata),
    .irq(irq), .term_in(term_in), .pins(pins));

  rsd_switch u_sw (
    .rot_clk(rot_clk), .pins(pins), .closed(sw_closed), .pair(sw_pair),
    .term_in(term_in));

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  initial begin
    rot_clk = 1'b0;
    #1.3;
    forever #3 rot_clk = ~rot_clk;
  end

  // ---------------------------------------------------------------
  // access and checking tasks
  // ---------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk);
    #1 req = '0;
  endtask

  task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    #1 req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk);
    #1 req = '0;
    @(posedge sys_clk);
    #1 check(reg_rdata, exp);
  endtask

  task automatic start_run;
    reg_write(8'h70, 8'h80);
    repeat (80) @(posedge sys_clk);
  endtask

  // turn the switch n positions, dir +1 up or -1 down
  task automatic walk(input int n, input int dir);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      #1 pos = (pos + dir + 3) % 3;
      sw_pair = pos[1:0];
      repeat (80) @(posedge sys_clk);
    end
    #1;
  endtask

  task automatic reset_pulse(input int which);
    @(posedge sys_clk);
    #1;
    case (which)
      0: rst = 1'b1;
      1: ext_rst_n = 1'b0;
      default: low_supply_lockout = 1'b1;
    endcase
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    ext_rst_n = 1'b1;
    low_supply_lockout = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  initial begin
    #200000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ext_rst_n = 1'b1;
    low_supply_lockout = 1'b0;
    req = '0;
    sw_closed = 1'b0;
    sw_pair = 2'h0;
    num_errors = 0;
    check_count = 0;
    pos = 0;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge sys_clk);
    expect_reg(8'h70, 8'h00);
    expect_reg(8'h72, 8'h00);
    expect_reg(8'h71, 8'h00);
    check({7'h00, irq}, 8'h00);
    $display("test reset values done");

    sw_closed = 1'b1;
    reg_write(8'h70, 8'hff);
    expect_reg(8'h70, 8'h80);
    reg_write(8'h72, 8'h55);
    repeat (80) @(posedge sys_clk);
    for (int i = 0; i < 24; i++) begin
      repeat (3) @(posedge sys_clk);
      check({7'h00, $onehot(pins.oe)}, 8'h01);
      check({2'b00, pins.pu, pins.oe}, {2'b00, ~pins.oe, pins.oe});
      check({5'h00, pins.out}, 8'h00);
    end
    expect_reg(8'h72, 8'h00);
    $display("test start and drive pattern done");

    walk(4, 1);
    check({7'h00, irq}, 8'h01);
    expect_reg(8'h72, 8'h04);
    expect_reg(8'h72, 8'h00);
    check({7'h00, irq}, 8'h00);
    walk(2, -1);
    expect_reg(8'h72, 8'h82);
    walk(1, -1);
    walk(2, 1);
    expect_reg(8'h72, 8'h02);
    $display("test direction done");

    walk(130, 1);
    expect_reg(8'h72, 8'h7f);
    $display("test saturation done");

    reg_write(8'h70, 8'h00);
    expect_reg(8'h70, 8'h00);
    walk(3, 1);
    expect_reg(8'h72, 8'h00);
    check({2'b00, pins.pu, pins.oe}, 8'h00);
    start_run();
    walk(1, 1);
    expect_reg(8'h72, 8'h01);
    $display("test stop and restart done");

    for (int s = 0; s < 3; s++) begin
      start_run();
      walk(2, 1);
      check({7'h00, irq}, 8'h01);
      reset_pulse(s);
      check({7'h00, irq}, 8'h00);
      expect_reg(8'h70, 8'h00);
      expect_reg(8'h72, 8'h00);
    end
    $display("test reset sources done");
    end_of_test();
  end
endmodule
